//--- psr_pkg.sv
// Purpose: Shared constants and types for the preset table command handler
// Assumes: 32-bit APB register words at byte offsets, four outputs per module
// Notes: Pulse unit and error code values are local decisions of this block
package psr_pkg;
  // Clock and pulse time base
  localparam int CLK_PERIOD_NS = 25;
  localparam int PULSE_UNIT_US = 1000;
  localparam int PULSE_UNIT_CYC = (PULSE_UNIT_US * 1000) / CLK_PERIOD_NS;

  localparam int NUM_OUT = 4;

  // Register byte offsets
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] TARGET_OFS = 8'h04;
  localparam logic [7:0] ENTRY_OFS = 8'h08;
  localparam logic [7:0] PRESET_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] ERRCODE_OFS = 8'h14;
  localparam logic [7:0] INT_STATUS_OFS = 8'h18;
  localparam logic [7:0] INT_CLEAR_OFS = 8'h1C;
  localparam logic [7:0] INT_ENABLE_OFS = 8'h20;

  // Command register bits (levels, acted on at their rising edge)
  localparam int CMD_CLEAR_BIT = 0;
  localparam int CMD_EDIT_BIT = 1;
  localparam int CMD_EDRL_BIT = 2;
  localparam int CMD_RDERR_BIT = 3;
  localparam int CMD_LOAD_BIT = 4;

  // Target and entry field positions
  localparam int TGT_MOD_LSB = 0;
  localparam int TGT_OUT_LSB = 8;
  localparam int TGT_TBL_LSB = 16;
  localparam int TGT_ENT_LSB = 24;
  localparam int ENT_TYPE_LSB = 0;
  localparam int ENT_PULSE_LSB = 16;

  // Status and interrupt bit positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_OK_BIT = 1;
  localparam int STAT_ERR_BIT = 2;
  localparam int STAT_OUT_LSB = 4;
  localparam int STAT_ARMED_LSB = 8;
  localparam int INT_OK_BIT = 0;
  localparam int INT_ERR_BIT = 1;

  // Reset values and limits
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [1:0] INT_EN_RST = 2'h0;
  localparam logic [31:0] MAX_PRESET = 32'h7FFF_4020;

  typedef enum logic [7:0] {
    ERR_NONE = 8'h00,
    ERR_MODULE = 8'h01,
    ERR_TYPE = 8'h02,
    ERR_COUNT = 8'h03,
    ERR_ENTRY = 8'h04,
    ERR_TABLE = 8'h05
  } psr_err_e;

  typedef enum logic [2:0] {
    ET_SET = 3'b000,
    ET_RESET = 3'b001,
    ET_PULSE_ON = 3'b010,
    ET_PULSE_OFF = 3'b011,
    ET_TOGGLE = 3'b100,
    ET_RST_COUNT = 3'b101
  } psr_etype_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CLEAR = 3'b001,
    ST_WRITE = 3'b010,
    ST_RELOAD = 3'b011,
    ST_FINISH = 3'b100
  } psr_state_e;

  typedef enum logic [2:0] {
    OP_CLEAR = 3'b000,
    OP_EDIT = 3'b001,
    OP_EDRL = 3'b010,
    OP_RDERR = 3'b011,
    OP_LOAD = 3'b100
  } psr_op_e;

  typedef struct packed {
    logic valid;
    logic [2:0] etype;
    logic [15:0] pulse;
    logic [31:0] count;
  } psr_entry_s;
endpackage : psr_pkg

//--- psr_ram_if.sv
// Purpose: Port of the preset entry memory between handler and storage
// Assumes: One port, synchronous read with one cycle of latency
// Notes: The handler owns the port; the memory only answers
interface psr_ram_if import psr_pkg::*; #(parameter int AW = 10);
  logic we;
  logic [AW-1:0] addr;
  psr_entry_s wdata;
  psr_entry_s rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface : psr_ram_if

//--- psr_table_ram.sv
// Purpose: Preset entry storage, one region of entries per output
// Assumes: Address is the output number above the entry index
// Notes: Contents are not reset; the clear command empties a region
module psr_table_ram import psr_pkg::*; #(
  parameter int AW = 10
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Memory port
  psr_ram_if.mem ram
);
  typedef struct packed {
    psr_entry_s rdata;
  } psr_ram_state_s;

  psr_entry_s mem_arr [2**AW];
  psr_ram_state_s r_reg;
  psr_ram_state_s r_next;

  always_comb begin
    r_next = r_reg;
    r_next.rdata = mem_arr[ram.addr];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  // Storage array kept out of the reset so it can map onto block memory
  always_ff @(posedge pclk) begin
    if (ce && ram.we) begin
      mem_arr[ram.addr] <= ram.wdata;
    end
  end

  assign ram.rdata = r_reg.rdata;
endmodule : psr_table_ram

//--- psr_cmd_handler.sv
// Purpose: Preset table command handler with APB registers and preset engine
// Assumes: count_val comes from counter logic on pclk, no synchroniser needed
// Notes: One command at a time; entry index width ENTRY_W must be 1 to 8
//
// The APB register port and the placing of the registers were chosen for this implementation.
module psr_cmd_handler import psr_pkg::*; #(
  parameter int ENTRY_W = 8,
  parameter logic [7:0] MODULE_ID = 8'h00, // Arbitrary default
  parameter int PULSE_CYC = PULSE_UNIT_CYC
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Counter side
  input wire logic [3:0][31:0] count_val,
  output logic [3:0] preset_out,
  output logic [3:0] count_reset,
  // Interrupt
  output logic irq
);
  localparam int AW = ENTRY_W + 2;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [4:0] cmd;
    logic [4:0] cmd_prev;
    logic [31:0] target;
    logic [31:0] ecfg;
    logic [31:0] preset;
    logic busy;
    logic ok;
    logic err;
    logic [7:0] fail;
    logic [7:0] last_err;
    logic [7:0] err_view;
    logic [1:0] int_st;
    logic [1:0] int_en;
    logic irq;
    psr_state_e st;
    psr_op_e op;
    logic [ENTRY_W-1:0] idx;
    logic [3:0] armed;
    logic [3:0][7:0] tbl;
    logic [3:0][ENTRY_W-1:0] ptr;
    logic [1:0] rr;
    logic [1:0] rd_out;
    logic rd_pend;
    logic [3:0] outq;
    logic [3:0] rstq;
    logic [3:0][15:0] pulse;
    logic [31:0] tick;
  } psr_hstate_s;

  psr_hstate_s r_reg;
  psr_hstate_s r_next;

  psr_ram_if #(.AW(AW)) ram_bus ();

  psr_table_ram #(.AW(AW)) u_ram (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .ram(ram_bus)
  );

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == CMD_OFS) || (a == TARGET_OFS) || (a == ENTRY_OFS) ||
              (a == PRESET_OFS) || (a == STATUS_OFS) || (a == ERRCODE_OFS) ||
              (a == INT_STATUS_OFS) || (a == INT_CLEAR_OFS) || (a == INT_ENABLE_OFS);
  endfunction : reg_hit

  // Parameter check done once at acceptance, so a bad command touches nothing
  function automatic logic [7:0] cmd_check(input psr_op_e op, input logic [31:0] tgt,
                                           input logic [31:0] ecf, input logic [31:0] pre,
                                           input logic [7:0] cur_tbl);
    logic edit_op;
    logic [7:0] ent;
    edit_op = (op == OP_EDIT) || (op == OP_EDRL);
    ent = tgt[TGT_ENT_LSB +: 8];
    cmd_check = ERR_NONE;
    if (tgt[TGT_MOD_LSB +: 8] != MODULE_ID) begin
      cmd_check = ERR_MODULE;
    end else if (edit_op && (ecf[ENT_TYPE_LSB +: 3] > ET_RST_COUNT)) begin
      cmd_check = ERR_TYPE;
    end else if (edit_op && (pre > MAX_PRESET)) begin
      cmd_check = ERR_COUNT;
    end else if (edit_op && ((ent >> ENTRY_W) != 8'h00)) begin
      cmd_check = ERR_ENTRY;
    end else if ((op == OP_EDIT) && (tgt[TGT_TBL_LSB +: 8] != cur_tbl)) begin
      cmd_check = ERR_TABLE;
    end
  endfunction : cmd_check

  logic [4:0] rise;
  logic [1:0] int_clr;
  logic [1:0] int_ev;
  logic tick_hit;
  logic [1:0] sel_out;
  psr_op_e new_op;
  psr_entry_s ent_rd;

  always_comb begin
    r_next = r_reg;
    r_next.rstq = '0;
    r_next.pready = 1'b0;
    r_next.pslverr = 1'b0;
    int_clr = '0;
    int_ev = '0;
    new_op = OP_CLEAR;
    sel_out = r_reg.target[TGT_OUT_LSB +: 2];
    ent_rd = ram_bus.rdata;
    ram_bus.we = 1'b0;
    ram_bus.addr = {r_reg.rr, r_reg.ptr[r_reg.rr]};
    ram_bus.wdata = '0;

    // APB setup: answer is prepared so the access phase completes at once
    if (psel && !penable) begin
      r_next.pready = 1'b1;
      r_next.pslverr = !reg_hit(paddr);
      r_next.prdata = REG_RST;
      if (paddr == CMD_OFS) begin
        r_next.prdata = {27'h000_0000, r_reg.cmd};
      end else if (paddr == TARGET_OFS) begin
        r_next.prdata = r_reg.target;
      end else if (paddr == ENTRY_OFS) begin
        r_next.prdata = r_reg.ecfg;
      end else if (paddr == PRESET_OFS) begin
        r_next.prdata = r_reg.preset;
      end else if (paddr == STATUS_OFS) begin
        r_next.prdata[STAT_BUSY_BIT] = r_reg.busy;
        r_next.prdata[STAT_OK_BIT] = r_reg.ok;
        r_next.prdata[STAT_ERR_BIT] = r_reg.err;
        r_next.prdata[STAT_OUT_LSB +: 4] = r_reg.outq;
        r_next.prdata[STAT_ARMED_LSB +: 4] = r_reg.armed;
      end else if (paddr == ERRCODE_OFS) begin
        r_next.prdata = {24'h00_0000, r_reg.err_view};
      end else if (paddr == INT_STATUS_OFS) begin
        r_next.prdata = {30'h0000_0000, r_reg.int_st};
      end else if (paddr == INT_ENABLE_OFS) begin
        r_next.prdata = {30'h0000_0000, r_reg.int_en};
      end
    end

    // APB write takes effect at the completing access edge only
    if (psel && penable && r_reg.pready && pwrite) begin
      if (paddr == CMD_OFS) begin
        r_next.cmd = pwdata[4:0];
      end else if (paddr == TARGET_OFS) begin
        r_next.target = pwdata;
      end else if (paddr == ENTRY_OFS) begin
        r_next.ecfg = pwdata;
      end else if (paddr == PRESET_OFS) begin
        r_next.preset = pwdata;
      end else if (paddr == INT_CLEAR_OFS) begin
        int_clr = pwdata[1:0];
      end else if (paddr == INT_ENABLE_OFS) begin
        r_next.int_en = pwdata[1:0];
      end
    end

    // Pulse timers run first so a firing entry in the same cycle overrides them
    tick_hit = (r_reg.tick == 32'(PULSE_CYC - 1));
    r_next.tick = tick_hit ? 32'h0000_0000 : r_reg.tick + 32'h0000_0001;
    for (int o = 0; o < NUM_OUT; o++) begin
      if (tick_hit && (r_reg.pulse[o] != 16'h0000)) begin
        r_next.pulse[o] = r_reg.pulse[o] - 16'h0001;
        if (r_reg.pulse[o] == 16'h0001) begin
          r_next.outq[o] = ~r_reg.outq[o];
        end
      end
    end

    // Preset engine: reads one entry per idle cycle, round robin over outputs.
    // It stops while a command owns the memory port, so it never acts on a
    // stale read of an entry that the command is rewriting.
    r_next.rd_pend = 1'b0;
    if (r_reg.st == ST_IDLE) begin
      r_next.rd_pend = 1'b1;
      r_next.rd_out = r_reg.rr;
      r_next.rr = r_reg.rr + 2'h1;
      if (r_reg.rd_pend && r_reg.armed[r_reg.rd_out] && ent_rd.valid &&
          (count_val[r_reg.rd_out] >= ent_rd.count)) begin
        case (ent_rd.etype)
          ET_SET: r_next.outq[r_reg.rd_out] = 1'b1;
          ET_RESET: r_next.outq[r_reg.rd_out] = 1'b0;
          ET_PULSE_ON: begin
            r_next.outq[r_reg.rd_out] = 1'b1;
            r_next.pulse[r_reg.rd_out] = ent_rd.pulse;
          end
          ET_PULSE_OFF: begin
            r_next.outq[r_reg.rd_out] = 1'b0;
            r_next.pulse[r_reg.rd_out] = ent_rd.pulse;
          end
          ET_TOGGLE: r_next.outq[r_reg.rd_out] = ~r_reg.outq[r_reg.rd_out];
          ET_RST_COUNT: r_next.rstq[r_reg.rd_out] = 1'b1;
          default: r_next.outq[r_reg.rd_out] = r_reg.outq[r_reg.rd_out];
        endcase
        r_next.ptr[r_reg.rd_out] = r_reg.ptr[r_reg.rd_out] + 1'b1;
        if (&r_reg.ptr[r_reg.rd_out]) begin
          r_next.armed[r_reg.rd_out] = 1'b0;
        end
      end
    end

    // Command sequencer
    rise = r_reg.cmd & ~r_reg.cmd_prev;
    r_next.cmd_prev = r_reg.cmd;
    case (r_reg.st)
      ST_IDLE: begin
        if (|rise) begin
          if (rise[CMD_CLEAR_BIT]) begin
            new_op = OP_CLEAR;
          end else if (rise[CMD_EDIT_BIT]) begin
            new_op = OP_EDIT;
          end else if (rise[CMD_EDRL_BIT]) begin
            new_op = OP_EDRL;
          end else if (rise[CMD_RDERR_BIT]) begin
            new_op = OP_RDERR;
          end else begin
            new_op = OP_LOAD;
          end
          r_next.op = new_op;
          r_next.busy = 1'b1;
          r_next.ok = 1'b0;
          r_next.err = 1'b0;
          r_next.idx = '0;
          r_next.fail = cmd_check(new_op, r_reg.target, r_reg.ecfg, r_reg.preset,
                                  r_reg.tbl[sel_out]);
          if (r_next.fail != ERR_NONE) begin
            r_next.st = ST_FINISH;
          end else if (new_op == OP_CLEAR) begin
            r_next.st = ST_CLEAR;
          end else if ((new_op == OP_EDIT) || (new_op == OP_EDRL)) begin
            r_next.st = ST_WRITE;
          end else if (new_op == OP_LOAD) begin
            r_next.st = ST_RELOAD;
          end else begin
            r_next.err_view = r_reg.last_err;
            r_next.st = ST_FINISH;
          end
        end
      end
      ST_CLEAR: begin
        ram_bus.we = 1'b1;
        ram_bus.addr = {sel_out, r_reg.idx};
        r_next.idx = r_reg.idx + 1'b1;
        r_next.armed[sel_out] = 1'b0;
        r_next.ptr[sel_out] = '0;
        if (&r_reg.idx) begin
          r_next.st = ST_FINISH;
        end
      end
      ST_WRITE: begin
        ram_bus.we = 1'b1;
        ram_bus.addr = {sel_out, r_reg.target[TGT_ENT_LSB +: ENTRY_W]};
        ram_bus.wdata.valid = 1'b1;
        ram_bus.wdata.etype = r_reg.ecfg[ENT_TYPE_LSB +: 3];
        ram_bus.wdata.pulse = r_reg.ecfg[ENT_PULSE_LSB +: 16];
        ram_bus.wdata.count = r_reg.preset;
        r_next.st = (r_reg.op == OP_EDRL) ? ST_RELOAD : ST_FINISH;
      end
      ST_RELOAD: begin
        r_next.ptr[sel_out] = '0;
        r_next.armed[sel_out] = 1'b1;
        r_next.tbl[sel_out] = r_reg.target[TGT_TBL_LSB +: 8];
        r_next.st = ST_FINISH;
      end
      ST_FINISH: begin
        r_next.busy = 1'b0;
        r_next.ok = (r_reg.fail == ERR_NONE);
        r_next.err = (r_reg.fail != ERR_NONE);
        if (r_reg.fail != ERR_NONE) begin
          r_next.last_err = r_reg.fail;
        end
        int_ev[INT_OK_BIT] = (r_reg.fail == ERR_NONE);
        int_ev[INT_ERR_BIT] = (r_reg.fail != ERR_NONE);
        r_next.st = ST_IDLE;
      end
      default: r_next.st = ST_IDLE;
    endcase

    // A completion in the same cycle as a clear keeps its bit set
    r_next.int_st = (r_reg.int_st & ~int_clr) | int_ev;
    r_next.irq = |(r_next.int_st & r_next.int_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
      r_reg.int_en <= INT_EN_RST;
      r_reg.st <= ST_IDLE;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign preset_out = r_reg.outq;
  assign count_reset = r_reg.rstq;
  assign irq = r_reg.irq;
endmodule : psr_cmd_handler

//--- psr_cmd_handler_monitor.sv
// Purpose: Port-level checks of the preset table command handler
// Assumes: Only aligned addresses are used; one clock domain
// Notes: Interrupt enable is shadowed from APB writes
module psr_cmd_handler_monitor import psr_pkg::*; (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Counter side and interrupt
  input wire logic [3:0] count_reset,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [1:0] en_reg;
  logic acc;
  logic rd_st;
  assign acc = ce && psel && penable && pready;
  assign rd_st = acc && !pwrite && paddr == STATUS_OFS;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= 2'h0;
    end else if (acc && pwrite && paddr == INT_ENABLE_OFS) begin
      en_reg <= pwdata[1:0];
    end
  end
  status_excl_a: assert property (rd_st |-> !(prdata[STAT_OK_BIT] && prdata[STAT_ERR_BIT]))
    else $error("Success and error shown together");
  busy_flags_a: assert property (rd_st && prdata[STAT_BUSY_BIT] |-> prdata[2:1] == 2'b00)
    else $error("Completion flag while busy");
  irq_masked_a: assert property ((en_reg == 2'h0) [*2] |-> !irq)
    else $error("Interrupt while all sources masked");
  rst_pulse_a: assert property (count_reset != 4'h0 |=> (count_reset & $past(count_reset)) == 4'h0)
    else $error("Count reset longer than one cycle");
  apb_answer_a: assert property (psel && !penable && ce |=> pready)
    else $error("No answer after setup");
  apb_pulse_a: assert property (pready && ce |=> !pready)
    else $error("Ready held too long");
  apb_map_a: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > INT_ENABLE_OFS))
    else $error("Wrong slave error");
  apb_err_data_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("Slave error without ready or with data");
  cover property (rd_st && prdata[STAT_ERR_BIT]);
  cover property (rd_st && prdata[STAT_OK_BIT]);
  cover property (irq);
  cover property (count_reset != 4'h0);
endmodule : psr_cmd_handler_monitor

bind psr_cmd_handler psr_cmd_handler_monitor chk (.pclk, .presetn, .ce, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .count_reset, .irq);

//--- psr_counter_model.sv
// Purpose: Counter partner feeding live counts to the handler
// Assumes: Bench starts, stops and zeroes each counter
// Notes: A count reset pulse zeroes the counter at the next edge
module psr_counter_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control
  input wire logic [3:0] run,
  input wire logic [3:0] zero,
  // Handler side
  input wire logic [3:0] count_reset,
  output logic [3:0][31:0] count_val
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_val <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (zero[i] || count_reset[i]) begin
          count_val[i] <= 32'h0000_0000;
        end else if (run[i]) begin
          count_val[i] <= count_val[i] + 32'h0000_0001;
        end
      end
    end
  end
endmodule : psr_counter_model

//--- psr_cmd_handler_tb.sv
// Purpose: Self-checking bench of the preset table command handler
// Assumes: Short entry region and pulse unit to keep the run brief
// Notes: Errors are tried before any reload so table 0 is still loaded
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %0t: mismatch", $time); end end
module psr_cmd_handler_tb import psr_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] MID = 8'hA5; // Arbitrary value
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic [3:0] preset_out, count_reset, run = 4'h0, zero = 4'h0;
  logic [3:0][31:0] count_val;
  logic [7:0] codes [6] = '{8'h01, 8'h02, 8'h02, 8'h03, 8'h04, 8'h05};
  int fail_count = 0, n_compared = 0, n;
  psr_cmd_handler #(.ENTRY_W(4), .MODULE_ID(MID), .PULSE_CYC(4)) uut (.pclk, .presetn,
    .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .count_val, .preset_out, .count_reset, .irq);
  psr_counter_model cnt (.pclk, .presetn, .run, .zero, .count_reset, .count_val);
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  task automatic give_verdict();
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic bad();
    fail_count++;
    $display("Error %0t: timeout", $time);
    give_verdict();
  endtask : bad
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic er);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) bad();
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, d, r, er);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic er;
    apb(1'b0, a, 32'h0000_0000, r, er);
  endtask : rd
  task automatic setp(input logic [1:0] o, input logic [7:0] t, input logic [7:0] en,
    input logic [2:0] ty, input logic [15:0] pu, input logic [31:0] c, input logic [7:0] m = MID);
    wr(TARGET_OFS, {en, t, 6'h00, o, m});
    wr(ENTRY_OFS, {pu, 13'h0000, ty});
    wr(PRESET_OFS, c);
  endtask : setp
  task automatic poll(output logic [31:0] st);
    int k;
    k = 0;
    do begin
      rd(STATUS_OFS, st);
      k++;
    end while (st[STAT_BUSY_BIT] !== 1'b0 && k < 100);
    if (k >= 100) bad();
  endtask : poll
  task automatic cmd(input int b, input logic [1:0] ok_err);
    logic [31:0] st;
    wr(CMD_OFS, 32'h0000_0000);
    wr(CMD_OFS, 32'h1 << b);
    poll(st);
    `CHK({st[STAT_ERR_BIT], st[STAT_OK_BIT]}, ok_err)
  endtask : cmd
  task automatic wait_po(input int i, input logic v);
    n = 0;
    while (preset_out[i] !== v && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) bad();
  endtask : wait_po
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(INT_ENABLE_OFS, q);
    `CHK(q, 32'h0000_0000)
    apb(1'b0, 8'h40, 32'h0000_0000, q, e);
    `CHK({e, q}, {1'b1, 32'h0000_0000})
    for (int o = 0; o < 4; o++) begin
      // Entry out of range: the ignored edit would end in error if it were taken
      setp(o[1:0], 8'h00, 8'h10, ET_SET, 16'h0000, 32'h0000_0000);
      wr(CMD_OFS, 32'h0000_0000);
      wr(CMD_OFS, 32'h1 << CMD_CLEAR_BIT);
      rd(STATUS_OFS, q);
      `CHK(q[2:0], 3'b001)
      wr(CMD_OFS, 32'h0000_0000);
      wr(CMD_OFS, 32'h1 << CMD_EDIT_BIT);
      poll(q);
      `CHK({q[STAT_ARMED_LSB + o], q[2:0]}, 4'b0010)
    end
    for (int i = 0; i < 6; i++) begin
      setp(2'd0, i == 5 ? 8'h03 : 8'h00, i == 4 ? 8'h10 : 8'h00,
           i == 1 ? 3'h6 : i == 2 ? 3'h7 : 3'h0, 16'h0000,
           i == 3 ? MAX_PRESET + 32'h1 : 32'h0, i == 0 ? MID + 8'h01 : MID);
      cmd(CMD_EDIT_BIT, 2'b10);
      // Read-error also names the module, so it must carry our own number
      wr(TARGET_OFS, {24'h00_0000, MID});
      cmd(CMD_RDERR_BIT, 2'b01);
      rd(ERRCODE_OFS, q);
      `CHK(q[7:0], codes[i])
    end
    setp(2'd0, 8'h00, 8'h0F, ET_SET, 16'h0000, MAX_PRESET);
    cmd(CMD_EDIT_BIT, 2'b01);
    rd(INT_STATUS_OFS, q);
    `CHK(q[1:0], 2'b11)
    wr(INT_ENABLE_OFS, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b1)
    wr(INT_CLEAR_OFS, 32'h0000_0003);
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b0)
    setp(2'd0, 8'h00, 8'h00, ET_SET, 16'h0000, 32'd10);
    cmd(CMD_EDRL_BIT, 2'b01);
    run[0] <= 1'b1;
    wait_po(0, 1'b1);
    `CHK(count_val[0] >= 10 && count_val[0] <= 20, 1'b1)
    run[0] <= 1'b0;
    zero[0] <= 1'b1;
    setp(2'd0, 8'h00, 8'h01, ET_RESET, 16'h0000, 32'd20);
    zero[0] <= 1'b0;
    cmd(CMD_EDIT_BIT, 2'b01);
    cmd(CMD_LOAD_BIT, 2'b01);
    run[0] <= 1'b1;
    wait_po(0, 1'b0);
    `CHK(count_val[0] >= 20 && count_val[0] <= 30, 1'b1)
    setp(2'd1, 8'h00, 8'h00, ET_SET, 16'h0000, 32'd10);
    cmd(CMD_EDRL_BIT, 2'b01);
    cmd(CMD_CLEAR_BIT, 2'b01);
    run[1] <= 1'b1;
    repeat (40) @(posedge pclk);
    rd(STATUS_OFS, q);
    `CHK({q[STAT_ARMED_LSB + 1], preset_out[1]}, 2'b00)
    setp(2'd2, 8'h00, 8'h01, ET_RST_COUNT, 16'h0000, 32'd30);
    cmd(CMD_EDIT_BIT, 2'b01);
    setp(2'd2, 8'h00, 8'h00, ET_PULSE_ON, 16'h0002, 32'd0);
    cmd(CMD_EDRL_BIT, 2'b01);
    run[2] <= 1'b1;
    wait_po(2, 1'b1);
    n = 0;
    while (preset_out[2] === 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    // Two units of four cycles; the first unit may be partly gone already
    `CHK(n >= 5 && n <= 8, 1'b1)
    n = 0;
    while (count_reset[2] !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    `CHK(n < 200, 1'b1)
    setp(2'd3, 8'h00, 8'h00, ET_SET, 16'h0002, 32'd0);
    cmd(CMD_EDRL_BIT, 2'b01);
    wait_po(3, 1'b1);
    repeat (30) @(posedge pclk);
    `CHK(preset_out[3], 1'b1)
    setp(2'd3, 8'h00, 8'h01, ET_TOGGLE, 16'h0000, 32'd0);
    cmd(CMD_EDIT_BIT, 2'b01);
    setp(2'd3, 8'h00, 8'h02, ET_PULSE_OFF, 16'h0001, 32'd0);
    cmd(CMD_EDIT_BIT, 2'b01);
    cmd(CMD_LOAD_BIT, 2'b01);
    wait_po(3, 1'b0);
    wait_po(3, 1'b1);
    // Low from the toggle: one engine visit, then one pulse unit
    `CHK(n >= 5 && n <= 8, 1'b1)
    give_verdict();
  end
endmodule : psr_cmd_handler_tb
